// [adcsr_chk.sv]
// link assertions
`timescale 1ns/10ps
`default_nettype none
module adcsr_chk #(
   parameter int CONV_CNT = 60
)(
   // system
   input wire logic clk_sys,
   input wire logic rst,
   // link pins
   input wire logic [2:0] pair_convert_start,
   input wire logic busy,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic rd_n,
   input wire logic serial_parallel_select,
   input wire logic soft_select,
   input wire logic chain_enable,
   input wire logic [2:0] line_sel,
   input wire logic [2:0] dout,
   input wire logic [2:0] dout_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ---------------------------------------------------------------
   // helper state
   // ---------------------------------------------------------------
   logic [2:0] start_q_r, start_q_nxt, rise;
   int busy_cnt_r, busy_cnt_nxt;
   always_comb begin
      start_q_nxt = pair_convert_start;
      busy_cnt_nxt = busy ? busy_cnt_r + 1 : 0;
      rise = pair_convert_start & ~start_q_r;
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         start_q_r <= 3'h0;
         busy_cnt_r <= 0;
      end else begin
         start_q_r <= start_q_nxt;
         busy_cnt_r <= busy_cnt_nxt;
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   // soft mode: pair a only
   sequence s_start;
      !busy && (soft_select ? rise[0] : (rise != 3'h0));
   endsequence
   // let pins cross the synchronisers
   sequence s_steady;
      $stable({cs_n, line_sel, serial_parallel_select})[*4];
   endsequence
   chk_busy_width: assert property ($fell(busy) |-> busy_cnt_r == CONV_CNT)
      else $error("busy width");
   chk_busy_bound: assert property (busy_cnt_r <= CONV_CNT)
      else $error("busy too long");
   chk_start_busy: assert property (s_start |-> ##[1:6] busy)
      else $error("no busy after start");
   chk_oe_lines: assert property (s_steady |->
      dout_oe == ({3{!cs_n & serial_parallel_select}} & line_sel))
      else $error("oe vs line select");
   chk_cs_fall_oe: assert property ($fell(cs_n) |-> ##[1:5] dout_oe == line_sel)
      else $error("oe not on at frame");
   chk_shift_rise: assert property ($fell(sclk) |-> $stable(dout)[*8])
      else $error("data moved, sclk low");
   chk_sclk_idle: assert property (cs_n |-> sclk)
      else $error("sclk not idle high");
   chk_read_mode: assert property (!cs_n && !sclk |-> serial_parallel_select && !rd_n)
      else $error("read mode pins");
   chk_chain_wait: assert property ($fell(cs_n) && chain_enable |-> !busy)
      else $error("chain read while busy");
endmodule
`default_nettype wire

// [adcsr_device.sv]
// converter end: conversion, range and serial shift-out
//
// Function
// - software mode: pair range from its range bit
// - start edge samples pair, busy for 3us
// - start edges ignored while busy
// - host holds serial select high, read low
// - each line select enables its data line
// - three lines: one 32 or two 16 frames
// - two lines: A gets 1,2,5; B 3,4,6
// - one line: 96, 3x32 or 6x16 clocks
// - zeros after all results shifted out
// - unused pairs keep slots, filled with zeros
// - chip select fall enables outputs, shows MSB
// - sixteen bits per result, MSB first
// - shift on rising edge, host samples falling
// - chain enable turns bus bits into chain inputs
// - chain reads start only after busy falls
// - chain: own results out, then upstream results
// - chain reads may split, enable held high
// - control byte latched on write strobe rise
`timescale 1ns/10ps
`default_nettype none
module adcsr_device
   import adcsr_pkg::*;
#(
   parameter int CONV_CNT = CONV_CYCLES
)(
   // system
   input wire logic clk_sys,
   input wire logic rst,
   // link pins
   adcsr_if.device lnk,
   // analog side
   input wire logic [NUM_CHAN-1:0][RES_BITS-1:0] chan_result,
   output logic conv_start,
   output logic [NUM_PAIRS-1:0] conv_pairs,
   output logic [NUM_PAIRS-1:0] pair_range_bit
);
   // ---------------------------------------------------------------
   // input synchroniser layout
   // ---------------------------------------------------------------
   localparam int IX_CONV = 0;
   localparam int IX_CS = 3;
   localparam int IX_SCLK = 4;
   localparam int IX_RD = 5;
   localparam int IX_WR = 6;
   localparam int IX_DB = 7;
   localparam int IX_CHN = 15;
   localparam int IX_LSEL = 18;
   localparam int IX_CEN = 21;
   localparam int IX_SER = 22;
   localparam int IX_SOFT = 23;
   localparam int IX_RNG = 24;
   localparam int SYNC_W = 25;

   logic [SYNC_W-1:0] pins;
   logic [SYNC_W-1:0] s1_r, s2_r, s3_r;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic busy_r, busy_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [NUM_PAIRS-1:0] used_r, used_nxt;
   logic [NUM_PAIRS-1:0] range_r, range_nxt;
   logic range_hw_r, range_hw_nxt;
   logic [NUM_LINES-1:0][SR_LEN-1:0] sr_r, sr_nxt;
   logic [NUM_LINES-1:0] chain_bit_r, chain_bit_nxt;
   logic [NUM_LINES-1:0] dout_r, dout_nxt;
   logic [NUM_LINES-1:0] oe_r, oe_nxt;
   logic conv_start_r, conv_start_nxt;
   logic [NUM_PAIRS-1:0] conv_pairs_r, conv_pairs_nxt;

   assign pins = {lnk.range_pin, lnk.soft_select, lnk.serial_parallel_select,
                  lnk.chain_enable, lnk.line_sel,
                  lnk.chain_in_c, lnk.chain_in_b, lnk.chain_in_a,
                  lnk.db_hi, lnk.wr_n, lnk.rd_n, lnk.sclk, lnk.cs_n,
                  lnk.pair_convert_start};

   // ---------------------------------------------------------------
   // synchronisers; s3 only serves edge detection on s2
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [NUM_PAIRS-1:0] rise;
      logic [NUM_PAIRS-1:0] trig;
      logic [NUM_CHAN-1:0][RES_BITS-1:0] res;
      logic sclk_rise, sclk_fall, wr_rise, active;
      logic [6:0] len;
      trig = '0;
      len = 7'(LEN_ONE_LINE);
      rise = s2_r[IX_CONV+:3] & ~s3_r[IX_CONV+:3];
      sclk_rise = s2_r[IX_SCLK] & ~s3_r[IX_SCLK];
      sclk_fall = ~s2_r[IX_SCLK] & s3_r[IX_SCLK];
      wr_rise = s2_r[IX_WR] & ~s3_r[IX_WR];
      active = ~s2_r[IX_CS] & s2_r[IX_SER];
      // line count follows the highest enabled select
      if (s2_r[IX_LSEL+2]) begin
         len = 7'(LEN_THREE_LINES);
      end else if (s2_r[IX_LSEL+1]) begin
         len = 7'(LEN_TWO_LINES);
      end else begin
         len = 7'(LEN_ONE_LINE);
      end
      for (int c = 0; c < NUM_CHAN; c++) begin
         // a pair not started still owns its slots, as zeros
         res[c] = used_r[c/2] ? chan_result[c] : '0;
      end
      ctrl_nxt = ctrl_r;
      busy_nxt = busy_r;
      cnt_nxt = cnt_r;
      used_nxt = used_r;
      range_nxt = range_r;
      range_hw_nxt = range_hw_r;
      sr_nxt = sr_r;
      chain_bit_nxt = chain_bit_r;
      conv_start_nxt = 1'b0;
      conv_pairs_nxt = conv_pairs_r;
      // strobe valid with select low, read high
      if (wr_rise && !s2_r[IX_CS] && s2_r[IX_RD]) begin
         ctrl_nxt = s2_r[IX_DB+:8];
      end
      // software mode: start A fires chosen pairs
      if (s2_r[IX_SOFT]) begin
         trig = {NUM_PAIRS{rise[0]}} & ctrl_r[CTRL_SEL_POS+:NUM_PAIRS];
      end else begin
         trig = rise;
      end
      if (busy_r) begin
         // any start edge in here is dropped
         if (cnt_r == 8'h00) begin
            busy_nxt = 1'b0;
            range_hw_nxt = s2_r[IX_RNG];
            // reload restarts every line from its first result
            sr_nxt = '0;
            if (len == 7'(LEN_THREE_LINES)) begin
               sr_nxt[0] = SR_LEN'({res[0], res[1]});
               sr_nxt[1] = SR_LEN'({res[2], res[3]});
               sr_nxt[2] = SR_LEN'({res[4], res[5]});
            end else if (len == 7'(LEN_TWO_LINES)) begin
               sr_nxt[0] = SR_LEN'({res[0], res[1], res[4]});
               sr_nxt[1] = SR_LEN'({res[2], res[3], res[5]});
            end else begin
               sr_nxt[0] = {res[0], res[1], res[2], res[3], res[4], res[5]};
            end
         end else begin
            cnt_nxt = cnt_r - 8'h01;
         end
      end else if (|trig) begin
         busy_nxt = 1'b1;
         cnt_nxt = 8'(CONV_CNT - 1);
         used_nxt = trig;
         conv_start_nxt = 1'b1;
         conv_pairs_nxt = trig;
         if (s2_r[IX_SOFT]) begin
            range_nxt = ctrl_r[CTRL_RNG_POS+:NUM_PAIRS];
         end else begin
            range_nxt = {NUM_PAIRS{range_hw_r}};
         end
      end
      for (int i = 0; i < NUM_LINES; i++) begin
         // upstream bit caught while the host samples ours
         if (active && sclk_fall) begin
            chain_bit_nxt[i] = s2_r[IX_CEN] & s2_r[IX_CHN+i];
         end
         // shift state survives between frames, so reads may split
         if (active && sclk_rise && !(busy_r && cnt_r == 8'h00)) begin
            // zeros fill in behind unless the chain feeds them
            sr_nxt[i] = {sr_r[i][SR_LEN-2:0], chain_bit_r[i]};
         end
         oe_nxt[i] = active & s2_r[IX_LSEL+i];
         // bit at len-1 is the MSB of the current 16-bit result
         dout_nxt[i] = oe_nxt[i] & sr_nxt[i][len-7'd1];
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_r <= CTRL_RESET;
         busy_r <= 1'b0;
         cnt_r <= 8'h00;
         used_r <= '0;
         range_r <= '0;
         range_hw_r <= 1'b0;
         sr_r <= '0;
         chain_bit_r <= '0;
         dout_r <= '0;
         oe_r <= '0;
         conv_start_r <= 1'b0;
         conv_pairs_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         busy_r <= busy_nxt;
         cnt_r <= cnt_nxt;
         used_r <= used_nxt;
         range_r <= range_nxt;
         range_hw_r <= range_hw_nxt;
         sr_r <= sr_nxt;
         chain_bit_r <= chain_bit_nxt;
         dout_r <= dout_nxt;
         oe_r <= oe_nxt;
         conv_start_r <= conv_start_nxt;
         conv_pairs_r <= conv_pairs_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign lnk.busy = busy_r;
   assign lnk.dout = dout_r;
   assign lnk.dout_oe = oe_r;
   assign conv_start = conv_start_r;
   assign conv_pairs = conv_pairs_r;
   assign pair_range_bit = range_r;
endmodule
`default_nettype wire

// [adcsr_host.sv]
// host end: starts, control write, framed reads into a fifo
`timescale 1ns/10ps
`default_nettype none
module adcsr_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 32
)(
   // system
   input wire logic clk_sys,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_r, rp_r;
   logic full, empty;

   assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign empty = (wp_r == rp_r);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rp_r[AW-1:0]];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (in_valid && !full) begin
            wp_r <= wp_r + 1'b1;
         end
         if (out_ready && !empty) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (in_valid && !full) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end
endmodule

module adcsr_host
   import adcsr_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic rst,
   // link pins
   adcsr_if.host lnk,
   // static configuration
   input wire logic [2:0] cfg_line_sel,
   input wire logic cfg_chain,
   input wire logic cfg_soft,
   input wire logic cfg_range,
   // commands
   input wire logic conv_req,
   input wire logic [NUM_PAIRS-1:0] conv_mask,
   input wire logic ctrl_req,
   input wire logic [7:0] ctrl_data,
   input wire logic read_req,
   input wire logic [6:0] read_bits,
   output logic cmd_ready,
   // received words, {line C, line B, line A}
   output logic word_valid,
   input wire logic word_ready,
   output logic [3*RES_BITS-1:0] word_data
);
   typedef enum logic [3:0] {H_IDLE, H_CONV, H_WAIT_HI, H_WAIT_LO, H_SCLK_HI,
                             H_SCLK_LO, H_CS_END, H_WR_LO, H_WR_HI} adcsr_hstate_e;
   adcsr_hstate_e st_r, st_nxt;
   logic [3:0] b1_r, b2_r;
   logic [3:0] tmr_r, tmr_nxt;
   logic [6:0] bits_r, bits_nxt;
   logic [3:0] grp_r, grp_nxt;
   logic [2:0][RES_BITS-1:0] rx_r, rx_nxt;
   logic [2:0] cv_r, cv_nxt;
   logic cs_n_r, cs_n_nxt, sclk_r, sclk_nxt, wr_n_r, wr_n_nxt, rd_n_r, rd_n_nxt;
   logic [7:0] db_r, db_nxt;
   logic db_oe_r, db_oe_nxt, push_r, push_nxt, ready_r, ready_nxt;
   logic [5:0] cfg_r;
   logic fifo_ready;
   logic tick;

   // ---------------------------------------------------------------
   // far-side busy and data: two flops first
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         b1_r <= '0;
         b2_r <= '0;
         cfg_r <= '0;
      end else begin
         b1_r <= {lnk.busy, lnk.dout};
         b2_r <= b1_r;
         cfg_r <= {cfg_range, cfg_soft, cfg_chain, cfg_line_sel};
      end
   end

   assign tick = (tmr_r == 4'(SCLK_HALF - 1));

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tick ? 4'h0 : tmr_r + 4'h1;
      bits_nxt = bits_r;
      grp_nxt = grp_r;
      rx_nxt = rx_r;
      cv_nxt = cv_r;
      cs_n_nxt = cs_n_r;
      sclk_nxt = sclk_r;
      wr_n_nxt = wr_n_r;
      rd_n_nxt = rd_n_r;
      db_nxt = db_r;
      db_oe_nxt = db_oe_r;
      push_nxt = 1'b0;
      unique case (st_r)
         H_IDLE: begin
            tmr_nxt = 4'h0;
            if (conv_req && |conv_mask) begin
               cv_nxt = conv_mask;
               st_nxt = H_CONV;
            end else if (ctrl_req) begin
               cs_n_nxt = 1'b0;
               wr_n_nxt = 1'b0;
               rd_n_nxt = 1'b1;
               db_nxt = ctrl_data;
               db_oe_nxt = 1'b1;
               st_nxt = H_WR_LO;
            end else if (read_req && read_bits != 7'h00) begin
               cs_n_nxt = 1'b0;
               bits_nxt = read_bits;
               grp_nxt = 4'h0;
               st_nxt = H_SCLK_HI;
            end
         end
         H_CONV: begin
            if (tick) begin
               cv_nxt = '0;
               st_nxt = H_WAIT_HI;
            end
         end
         H_WAIT_HI: begin
            if (b2_r[3]) begin
               st_nxt = H_WAIT_LO;
            end
         end
         H_WAIT_LO: begin
            // reads wait for busy to fall
            if (!b2_r[3]) begin
               st_nxt = H_IDLE;
            end
         end
         H_SCLK_HI: begin
            if (tick) begin
               if (bits_r == 7'h00) begin
                  cs_n_nxt = 1'b1;
                  st_nxt = H_CS_END;
               end else if (grp_r != 4'h0 || fifo_ready) begin
                  // a new word starts only with fifo room: clock stalls high
                  sclk_nxt = 1'b0;
                  for (int i = 0; i < 3; i++) begin
                     rx_nxt[i] = {rx_r[i][RES_BITS-2:0], b2_r[i]};
                  end
                  bits_nxt = bits_r - 7'h01;
                  grp_nxt = grp_r + 4'h1;
                  push_nxt = (grp_r == 4'hF);
                  st_nxt = H_SCLK_LO;
               end
            end
         end
         H_SCLK_LO: begin
            if (tick) begin
               sclk_nxt = 1'b1;
               st_nxt = H_SCLK_HI;
            end
         end
         H_CS_END: begin
            if (tick) begin
               st_nxt = H_IDLE;
            end
         end
         H_WR_LO: begin
            if (tick) begin
               wr_n_nxt = 1'b1;
               st_nxt = H_WR_HI;
            end
         end
         H_WR_HI: begin
            if (tick) begin
               cs_n_nxt = 1'b1;
               rd_n_nxt = 1'b0;
               db_oe_nxt = 1'b0;
               st_nxt = H_IDLE;
            end
         end
      endcase
      ready_nxt = (st_nxt == H_IDLE);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= H_IDLE;
         tmr_r <= 4'h0;
         bits_r <= 7'h00;
         grp_r <= 4'h0;
         rx_r <= '0;
         cv_r <= '0;
         cs_n_r <= 1'b1;
         sclk_r <= 1'b1;
         wr_n_r <= 1'b1;
         rd_n_r <= 1'b0;
         db_r <= 8'h00;
         db_oe_r <= 1'b0;
         push_r <= 1'b0;
         ready_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         bits_r <= bits_nxt;
         grp_r <= grp_nxt;
         rx_r <= rx_nxt;
         cv_r <= cv_nxt;
         cs_n_r <= cs_n_nxt;
         sclk_r <= sclk_nxt;
         wr_n_r <= wr_n_nxt;
         rd_n_r <= rd_n_nxt;
         db_r <= db_nxt;
         db_oe_r <= db_oe_nxt;
         push_r <= push_nxt;
         ready_r <= ready_nxt;
      end
   end

   adcsr_fifo #(.WIDTH(3*RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(push_r),
      .in_ready(fifo_ready),
      .in_data({rx_r[2], rx_r[1], rx_r[0]}),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(word_data)
   );

   assign lnk.pair_convert_start = cv_r;
   assign lnk.cs_n = cs_n_r;
   assign lnk.sclk = sclk_r;
   assign lnk.wr_n = wr_n_r;
   assign lnk.rd_n = rd_n_r;
   assign lnk.db_hi = db_r;
   assign lnk.db_oe = db_oe_r;
   assign lnk.serial_parallel_select = 1'b1;
   assign lnk.line_sel = cfg_r[2:0];
   assign lnk.chain_enable = cfg_r[3];
   assign lnk.soft_select = cfg_r[4];
   assign lnk.range_pin = cfg_r[5];
   assign cmd_ready = ready_r;
endmodule
`default_nettype wire

// [adcsr_if.sv]
// pin bundle joining both ends
`timescale 1ns/10ps
`default_nettype none
interface adcsr_if;
   logic [2:0] pair_convert_start;
   logic busy;
   logic cs_n;
   logic sclk;
   logic rd_n;
   logic wr_n;
   logic [7:0] db_hi;
   logic db_oe;
   logic serial_parallel_select;
   logic soft_select;
   logic range_pin;
   logic chain_enable;
   logic [2:0] line_sel;
   logic chain_in_a;
   logic chain_in_b;
   logic chain_in_c;
   logic [2:0] dout;
   logic [2:0] dout_oe;

   modport device (
      input pair_convert_start, cs_n, sclk, rd_n, wr_n, db_hi, db_oe,
      input serial_parallel_select, soft_select, range_pin, chain_enable, line_sel,
      input chain_in_a, chain_in_b, chain_in_c,
      output busy, dout, dout_oe
   );
   modport host (
      output pair_convert_start, cs_n, sclk, rd_n, wr_n, db_hi, db_oe,
      output serial_parallel_select, soft_select, range_pin, chain_enable, line_sel,
      input busy, dout, dout_oe
   );
endinterface
`default_nettype wire

// [adcsr_pkg.sv]
// shared constants of the serial readout
package adcsr_pkg;
   // ---------------------------------------------------------------
   // clock and conversion timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int CONV_TIME_NS = 3000;
   // a longest time rounds down to whole cycles
   localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int RES_BITS = 16;
   localparam int NUM_PAIRS = 3;
   localparam int NUM_CHAN = 6;
   localparam int NUM_LINES = 3;
   localparam int SR_LEN = 96;
   localparam int LEN_ONE_LINE = 96;
   localparam int LEN_TWO_LINES = 48;
   localparam int LEN_THREE_LINES = 32;
   localparam int FIFO_DEPTH = 32;
   // ---------------------------------------------------------------
   // control register, data bus bits 15..8 seen as bits 7..0
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CTRL_SEL_POS = 5;
   localparam int CTRL_RNG_POS = 2;
   // ---------------------------------------------------------------
   // host pacing, in system clock cycles
   // ---------------------------------------------------------------
   localparam int SCLK_HALF = 8;
endpackage

// [tb_top.sv]
// self-checking bench for both ends
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import adcsr_pkg::*;
;
   // ---------------------------------------------------------------
   // stimulus and model state
   // ---------------------------------------------------------------
   localparam int CONV_SHORT = 8;
   localparam logic [2:0] SC_LS [5] = '{3'h7, 3'h3, 3'h1, 3'h7, 3'h7};
   localparam logic [2:0] SC_MASK [5] = '{3'h7, 3'h2, 3'h7, 3'h7, 3'h7};
   localparam logic [7:0] SC_BITS [5] = '{8'h10, 8'h10, 8'h20, 8'h10, 8'h70};
   localparam int SC_RD [5] = '{3, 3, 3, 4, 5};
   localparam logic [7:0] CTL_SOFT = 8'hAC;
   logic clk_sys, rst, cfg_chain, cfg_soft, cfg_range, conv_req, ctrl_req, read_req;
   logic cmd_ready, word_valid, word_ready;
   logic [NUM_CHAN-1:0][RES_BITS-1:0] chan_result;
   logic [2:0] cfg_line_sel, conv_mask, conv_pairs, pair_range_bit, pairs_exp, up_bit;
   logic [7:0] ctrl_data;
   logic [6:0] read_bits;
   logic [47:0] word_data, lmask;
   logic [191:0] str [3];
   logic [95:0] up [3];
   logic [47:0] exp_q [$];
   int failures, tests_run, seed, pos, wpos, hold;
   logic sclk_q;
   adcsr_if lnk_if();
   assign lnk_if.chain_in_a = up_bit[0];
   assign lnk_if.chain_in_b = up_bit[1];
   assign lnk_if.chain_in_c = up_bit[2];
   adcsr_device #(.CONV_CNT(CONV_SHORT)) u_adcsr_device (.clk_sys, .rst, .lnk(lnk_if),
      .chan_result, .conv_start(), .conv_pairs, .pair_range_bit);
   adcsr_host u_adcsr_host (.clk_sys, .rst, .lnk(lnk_if), .cfg_line_sel, .cfg_chain,
      .cfg_soft, .cfg_range, .conv_req, .conv_mask, .ctrl_req, .ctrl_data, .read_req,
      .read_bits, .cmd_ready, .word_valid, .word_ready, .word_data);
   adcsr_chk #(.CONV_CNT(CONV_SHORT)) u_adcsr_chk (.clk_sys, .rst,
      .pair_convert_start(lnk_if.pair_convert_start), .busy(lnk_if.busy), .cs_n(lnk_if.cs_n),
      .sclk(lnk_if.sclk), .rd_n(lnk_if.rd_n), .soft_select(lnk_if.soft_select),
      .serial_parallel_select(lnk_if.serial_parallel_select), .line_sel(lnk_if.line_sel),
      .chain_enable(lnk_if.chain_enable), .dout(lnk_if.dout), .dout_oe(lnk_if.dout_oe));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic [15:0] seg(input int l, input int p);
      return (p < 192) ? str[l][191-p -: 16] : 16'h0;
   endfunction
   function automatic logic [2:0] bits(input int p);
      return (p < 192) ? {str[2][191-p], str[1][191-p], str[0][191-p]} : 3'h0;
   endfunction
   // 0 conv, 1 ctrl write, 2 read, 3 idle wait
   task automatic cmd(input int k, input logic [7:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 9000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 9000) begin
         failures++;
         complete_run();
      end
      conv_req <= (k == 0);
      ctrl_req <= (k == 1);
      read_req <= (k == 2);
      conv_mask <= d[2:0];
      ctrl_data <= d;
      read_bits <= d[6:0];
      @(posedge clk_sys);
      conv_req <= 1'b0;
      ctrl_req <= 1'b0;
      read_req <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   // per-line streams: own, then upstream, then zeros
   task automatic load(input logic [2:0] pm, input logic [2:0] ls, input logic ch);
      logic [15:0] r [6];
      logic [95:0] own [3];
      int len;
      for (int i = 0; i < 6; i++)
         r[i] = pm[i / 2] ? chan_result[i] : 16'h0;
      len = ls[2] ? 32 : (ls[1] ? 48 : 96);
      if (ls[2]) begin
         own[0] = {r[0], r[1], 64'h0};
         own[1] = {r[2], r[3], 64'h0};
      end else begin
         own[0] = ls[1] ? {r[0], r[1], r[4], 48'h0} : {r[0], r[1], r[2], r[3], r[4], r[5]};
         own[1] = {r[2], r[3], r[5], 48'h0};
      end
      own[2] = {r[4], r[5], 64'h0};
      for (int l = 0; l < 3; l++) begin
         up[l] = {$random(seed), $random(seed), $random(seed)} & ~({96{1'b1}} >> len);
         str[l] = {own[l], 96'h0} | (ch ? {up[l], 96'h0} >> len : 192'h0);
      end
      pos = 0;
      wpos = 0;
   endtask
   // ---------------------------------------------------------------
   // upstream, drain, monitors
   // ---------------------------------------------------------------
   // deselected upstream floats: show inverse
   always @(posedge clk_sys) begin
      for (int l = 0; l < 3; l++)
         up_bit[l] <= lnk_if.cs_n ? ~up_bit[l] : (wpos < 96 ? up[l][95-wpos] : 1'b0);
      word_ready <= (hold != 0) ? 1'b0 : 1'($random(seed));
   end
   always @(negedge clk_sys) begin
      if (sclk_q && !lnk_if.sclk)
         check({45'h0, lnk_if.dout & lnk_if.line_sel}, {45'h0, bits(wpos) & lnk_if.line_sel});
      if (!sclk_q && lnk_if.sclk)
         wpos++;
      sclk_q = lnk_if.sclk;
      if (word_valid === 1'b1 && word_ready === 1'b1)
         check(word_data & lmask, (exp_q.size() > 0) ? exp_q.pop_front() & lmask : 48'hX);
   end
   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      seed = 57216;
      {failures, tests_run, hold, pos, wpos} = '0;
      {sclk_q, rst} = 2'h3;
      {up_bit, word_ready, cfg_chain, cfg_soft, cfg_range, lmask} = '0;
      {conv_req, ctrl_req, read_req, conv_mask, ctrl_data, read_bits} = '0;
      cfg_line_sel = 3'h7;
      chan_result = '0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      for (int s = 0; s < 5; s++) begin
         cfg_line_sel <= SC_LS[s];
         cfg_chain <= (s == 3);
         cfg_soft <= (s == 2);
         lmask <= {{16{SC_LS[s][2]}}, {16{SC_LS[s][1]}}, {16{SC_LS[s][0]}}};
         for (int i = 0; i < NUM_CHAN; i++)
            chan_result[i] <= 16'($random(seed));
         repeat (4) @(posedge clk_sys);
         if (s == 2)
            cmd(1, CTL_SOFT);
         pairs_exp = (s == 2) ? CTL_SOFT[7:5] : SC_MASK[s];
         cmd(0, {5'h0, SC_MASK[s]});
         cmd(3, 8'h0);
         check({45'h0, conv_pairs}, {45'h0, pairs_exp});
         if (s == 2)
            check({45'h0, pair_range_bit}, {45'h0, CTL_SOFT[4:2]});
         load(pairs_exp, SC_LS[s], s == 3);
         hold = (s == 4);
         for (int r = 0; r < SC_RD[s]; r++) begin
            for (int g = 0; g < SC_BITS[s] / 16; g++) begin
               exp_q.push_back({seg(2, pos), seg(1, pos), seg(0, pos)});
               pos += 16;
            end
            cmd(2, SC_BITS[s]);
         end
         if (s == 4) begin
            // full buffer must stall the last read
            repeat (3000) @(posedge clk_sys);
            check({47'h0, cmd_ready}, 48'h0);
            check(48'(exp_q.size()), 48'h23);
            hold = 0;
         end
         cmd(3, 8'h0);
         for (int n = 0; n < 5000 && exp_q.size() > 0; n++)
            @(posedge clk_sys);
         check(48'(exp_q.size()), 48'h0);
      end
      complete_run();
   end
   // ~4x longest run
   initial begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      complete_run();
   end
endmodule
`default_nettype wire
